// ### logic/aco_top.sv
// analog comparator control: apb registers, flags, pin logic
`timescale 1ns/10ps
module aco_top #(
  parameter int ADDR_W = 8
) (
  input wire logic mclk,
  input wire logic rst_n,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [ADDR_W-1:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [3:0] pstrb,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic first_comparator_live_output,
  input wire logic second_comparator_live_output,
  input wire logic timer_compare_level,
  input wire logic extra_analog_option_mask,
  input wire logic [7:0] port_b_in,
  output logic [7:0] port_b_out,
  output logic [7:0] port_b_oe,
  output logic [7:0] port_b_pulldown_en,
  output logic first_comparator_power,
  output logic second_comparator_power,
  output logic bias_power,
  output logic comparator_sense_swap,
  output logic divider_connect,
  output logic current_source_on,
  output logic discharge_on,
  output logic analog_irq,
  output logic capture_trigger
);
  // =====================================================
  // elaboration check: index 0x1E needs byte address 0x78
  if (ADDR_W < 7) begin : g_addr_check
    $error("aco_top: ADDR_W must be at least 7");
  end

  // =====================================================
  // state
  typedef struct packed {
    logic [7:0] data;
    logic [7:0] dir;
    logic [7:0] pdd;
    logic [7:0] actl;
    logic [7:0] asel;
    logic flag1;
    logic flag2;
    logic [31:0] rdata;
  } aco_regs_t;
  aco_regs_t st_q;
  aco_regs_t st_d;

  logic rise1;
  logic rise2;
  logic [7:0] idx;
  logic hit;
  logic setup;
  logic wr;
  logic clr1;
  logic clr2;
  logic [7:0] status;
  logic [31:0] rd_word;
  logic current_function_enable;
  logic pin4_or;

  // =====================================================
  // edge detectors on both comparator outputs
  // rising edge capture
  aco_edge_sync u_sync1 (
    .mclk(mclk),
    .rst_n(rst_n),
    .async_in(first_comparator_live_output),
    .rise(rise1)
  );
  aco_edge_sync u_sync2 (
    .mclk(mclk),
    .rst_n(rst_n),
    .async_in(second_comparator_live_output),
    .rise(rise2)
  );

  // =====================================================
  // apb decode; word index from byte address
  assign idx = 8'(paddr[ADDR_W-1:2]);
  assign setup = psel & ~penable;
  always_comb begin
    unique case (idx)
      aco_pkg::IDX_PORT_B_DATA,
      aco_pkg::IDX_ANALOG_STATUS,
      aco_pkg::IDX_ANALOG_SELECT,
      aco_pkg::IDX_PORT_B_DIRECTION,
      aco_pkg::IDX_PORT_B_PULLDOWN_DISABLE,
      aco_pkg::IDX_ANALOG_CONTROL: hit = (paddr[1:0] == 2'h0);
      default: hit = 1'b0;
    endcase
  end
  // zero wait states; unmapped answers with an error
  assign pready = 1'b1;
  assign pslverr = psel & penable & ~hit;
  assign wr = psel & penable & pwrite & hit & pstrb[0];

  // write-one clear pulses, never stored
  assign clr1 = wr & (idx == aco_pkg::IDX_ANALOG_STATUS)
    & pwdata[aco_pkg::ASTAT_FIRST_CLEAR];
  assign clr2 = wr & (idx == aco_pkg::IDX_ANALOG_STATUS)
    & pwdata[aco_pkg::ASTAT_SECOND_CLEAR];

  // =====================================================
  // status view; live bits bypass any flop
  // live outputs unsynchronised
  always_comb begin
    status = aco_pkg::RST_BYTE;
    status[aco_pkg::ASTAT_FIRST_FLAG] = st_q.flag1;
    status[aco_pkg::ASTAT_SECOND_FLAG] = st_q.flag2;
    status[aco_pkg::ASTAT_FIRST_LIVE] = first_comparator_live_output;
    status[aco_pkg::ASTAT_SECOND_LIVE] = second_comparator_live_output;
  end

  // read mux; pulldown disable is write only and reads zero
  always_comb begin
    rd_word = aco_pkg::RST_WORD;
    unique case (idx)
      aco_pkg::IDX_PORT_B_DATA: rd_word[7:0] = st_q.data;
      aco_pkg::IDX_ANALOG_STATUS: rd_word[7:0] = status;
      aco_pkg::IDX_ANALOG_SELECT: rd_word[7:0] = st_q.asel;
      aco_pkg::IDX_PORT_B_DIRECTION: rd_word[7:0] = st_q.dir;
      aco_pkg::IDX_ANALOG_CONTROL: rd_word[7:0] = st_q.actl;
      default: rd_word = aco_pkg::RST_WORD;
    endcase
  end

  // =====================================================
  // next state
  always_comb begin
    st_d = st_q;
    // read data caught in setup, stable through access
    if (setup & ~pwrite) begin
      st_d.rdata = rd_word;
    end
    if (wr) begin
      unique case (idx)
        aco_pkg::IDX_PORT_B_DATA: st_d.data = pwdata[7:0];
        aco_pkg::IDX_ANALOG_SELECT: st_d.asel = pwdata[7:0];
        aco_pkg::IDX_PORT_B_DIRECTION: st_d.dir = pwdata[7:0];
        aco_pkg::IDX_PORT_B_PULLDOWN_DISABLE: st_d.pdd = pwdata[7:0];
        aco_pkg::IDX_ANALOG_CONTROL: st_d.actl = pwdata[7:0];
        default: st_d.data = st_q.data;
      endcase
    end
    st_d.flag1 = rise1 | (st_q.flag1 & ~clr1);
    st_d.flag2 = rise2 | (st_q.flag2 & ~clr2);
  end

  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      st_q <= '0;
    end else begin
      st_q <= st_d;
    end
  end

  assign prdata = st_q.rdata;

  // =====================================================
  // analog power and mode outputs
  // per-comparator power, shared bias
  assign first_comparator_power = st_q.actl[aco_pkg::ACTL_FIRST_POWER];
  assign second_comparator_power = st_q.actl[aco_pkg::ACTL_SECOND_POWER];
  assign bias_power = first_comparator_power | second_comparator_power;
  // one swap line for both comparators
  assign comparator_sense_swap = st_q.asel[aco_pkg::ASEL_SENSE_SWAP];
  assign divider_connect = st_q.asel[aco_pkg::ASEL_DIVIDED_INPUT];

  // both devices act on pin zero
  assign current_function_enable = st_q.actl[aco_pkg::ACTL_CURRENT_ENABLE];
  assign current_source_on = current_function_enable
    & st_q.actl[aco_pkg::ACTL_SOURCE_SELECT];
  assign discharge_on = current_function_enable
    & ~st_q.actl[aco_pkg::ACTL_SOURCE_SELECT];

  // =====================================================
  // interrupt and capture requests from latched flags
  // flags to analog irq and capture
  // capture path wins over analog irq
  assign capture_trigger = st_q.flag2
    & st_q.actl[aco_pkg::ACTL_CAPTURE_ENABLE];
  assign analog_irq = (st_q.flag1 | st_q.flag2)
    & st_q.actl[aco_pkg::ACTL_ANALOG_IRQ_ENABLE]
    & ~st_q.actl[aco_pkg::ACTL_CAPTURE_ENABLE];

  // =====================================================
  // port pins; pin four ORs its sources, software picks one
  // comparator joins only when enabled and masked in
  assign pin4_or = st_q.data[aco_pkg::PIN_SHARED] | timer_compare_level
    | (st_q.actl[aco_pkg::ACTL_FIRST_PIN_ENABLE]
       & extra_analog_option_mask & first_comparator_live_output);

  always_comb begin
    port_b_out = st_q.data;
    port_b_oe = st_q.dir;
    port_b_pulldown_en = ~st_q.pdd;
    // pin four drives OR, pulldown off
    port_b_out[aco_pkg::PIN_SHARED] = pin4_or;
    if (st_q.dir[aco_pkg::PIN_SHARED]) begin
      port_b_pulldown_en[aco_pkg::PIN_SHARED] = 1'b0;
    end
    // plain gpio while current function off
    if (current_function_enable) begin
      port_b_oe[aco_pkg::PIN_CURRENT_NODE] = 1'b0;
    end
  end
endmodule

// ### include/aco_pkg.sv
// constants for the analog comparator control block
// Contract
// - pulldown disable bits at 0x11 turn pulldowns off
// - comparator rising edge sets its latched flag
// - flag holds until clear bit or reset
// - flags raise analog irq; flag2 triggers capture
// - live outputs visible unsynchronised, unlatched
// - pin four drives only when direction set
// - pin four output: pulldown off, OR sources
// - comparator one joins OR when enabled, masked
// - capture enabled suppresses analog interrupt
// - enable and select pick source or discharge
// - enable clear leaves pin zero plain GPIO
// - comparator power bits; bias when either on
// - divider loads comparator two only when selected
// - pin zero carries source, discharge, comparator
// - config changes may set flags
// - sense swap drives both comparators together
package aco_pkg;
  // =====================================================
  // register indices; byte address is four times these
  localparam logic [7:0] IDX_PORT_B_DATA = 8'h00;
  localparam logic [7:0] IDX_ANALOG_STATUS = 8'h02;
  localparam logic [7:0] IDX_ANALOG_SELECT = 8'h03;
  localparam logic [7:0] IDX_PORT_B_DIRECTION = 8'h05;
  localparam logic [7:0] IDX_PORT_B_PULLDOWN_DISABLE = 8'h11;
  localparam logic [7:0] IDX_ANALOG_CONTROL = 8'h1E;
  // =====================================================
  // analog_control fields
  localparam int ACTL_FIRST_POWER = 0;
  localparam int ACTL_SECOND_POWER = 1;
  localparam int ACTL_CURRENT_ENABLE = 2;
  localparam int ACTL_SOURCE_SELECT = 3;
  localparam int ACTL_CAPTURE_ENABLE = 4;
  localparam int ACTL_ANALOG_IRQ_ENABLE = 5;
  localparam int ACTL_FIRST_PIN_ENABLE = 6;
  // analog_select fields
  localparam int ASEL_SENSE_SWAP = 0;
  localparam int ASEL_DIVIDED_INPUT = 1;
  // analog_status fields
  localparam int ASTAT_FIRST_FLAG = 0;
  localparam int ASTAT_SECOND_FLAG = 1;
  localparam int ASTAT_FIRST_LIVE = 2;
  localparam int ASTAT_SECOND_LIVE = 3;
  localparam int ASTAT_FIRST_CLEAR = 4;
  localparam int ASTAT_SECOND_CLEAR = 5;
  // =====================================================
  // port pin positions and reset values
  localparam int PIN_CURRENT_NODE = 0;
  localparam int PIN_SHARED = 4;
  localparam logic [7:0] RST_BYTE = 8'h00;
  localparam logic [31:0] RST_WORD = 32'h0000_0000;
endpackage

// ### logic/aco_edge_sync.sv
// two-flop synchroniser with rising edge pulse
`timescale 1ns/10ps
module aco_edge_sync (
  input wire logic mclk,
  input wire logic rst_n,
  input wire logic async_in,
  output logic rise
);
  // =====================================================
  // state
  typedef struct packed {
    logic meta;
    logic sync;
    logic last;
  } aco_sync_t;
  aco_sync_t st_q;
  aco_sync_t st_d;

  // meta feeds sync only; edge taken from the clean stages
  // synchronise then detect
  // config-driven output steps set flags too
  always_comb begin
    st_d = st_q;
    st_d.meta = async_in;
    st_d.sync = st_q.meta;
    st_d.last = st_q.sync;
  end

  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      st_q <= '0;
    end else begin
      st_q <= st_d;
    end
  end

  // one pulse per rising edge
  assign rise = st_q.sync & ~st_q.last;
endmodule

// ### dv/aco_analog_model.sv
// behavioural comparator pair standing at the block's analog inputs
`timescale 1ns/10ps
module aco_analog_model (
  input wire logic pwr1,
  input wire logic pwr2,
  input wire logic swap,
  input wire logic in1,
  input wire logic in2,
  output logic out1,
  output logic out2
);
  // =====================================================
  // outputs settle a few ns late, like a real comparator
  // swap inverts both outputs
  assign #3 out1 = pwr1 & (in1 ^ swap);
  assign #3 out2 = pwr2 & (in2 ^ swap);
endmodule

// ### dv/aco_top_checker.sv
// concurrent checks on the comparator control block's ports
`timescale 1ns/10ps
module aco_top_checker (
  input wire logic mclk,
  input wire logic rst_n,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic timer_compare_level,
  input wire logic [7:0] port_b_out,
  input wire logic [7:0] port_b_oe,
  input wire logic [7:0] port_b_pulldown_en,
  input wire logic first_comparator_power,
  input wire logic second_comparator_power,
  input wire logic bias_power,
  input wire logic current_source_on,
  input wire logic discharge_on,
  input wire logic analog_irq,
  input wire logic capture_trigger
);
  default clocking cb @(posedge mclk); endclocking
  default disable iff (!rst_n);
  // =====================================================
  // pin and power relations
  a_pin4_or_level: assert property (
    timer_compare_level |-> port_b_out[4]) else $error("pin four low");
  a_pin4_no_pull: assert property (
    port_b_oe[4] |-> !port_b_pulldown_en[4]) else $error("pin four pull");
  a_bias_follows: assert property (
    bias_power == (first_comparator_power | second_comparator_power))
    else $error("bias power wrong");
  a_source_excl: assert property (
    !(current_source_on && discharge_on)) else $error("source and sink");
  a_pin0_released: assert property (
    (current_source_on || discharge_on) |-> !port_b_oe[0])
    else $error("pin zero driven");
  // =====================================================
  // flag and interrupt relations
  a_capture_wins: assert property (
    capture_trigger |-> !analog_irq) else $error("irq beside capture");
  a_irq_holds: assert property (
    $fell(analog_irq) |-> $past(psel && penable && pwrite))
    else $error("irq dropped alone");
  a_capture_holds: assert property (
    $fell(capture_trigger) |-> $past(psel && penable && pwrite))
    else $error("capture dropped alone");
endmodule
bind aco_top aco_top_checker aco_top_checker_inst (.mclk, .rst_n, .psel,
  .penable, .pwrite, .timer_compare_level, .port_b_out, .port_b_oe,
  .port_b_pulldown_en, .first_comparator_power, .second_comparator_power,
  .bias_power, .current_source_on, .discharge_on, .analog_irq,
  .capture_trigger);

// ### dv/aco_top_tb_top.sv
// self-checking bench for the analog comparator control block
`timescale 1ns/10ps
module aco_top_tb_top;
  logic mclk = 1'b0, rst_n = 1'b0, psel = 1'b0, penable = 1'b0;
  logic pwrite = 1'b0, tcl = 1'b0, mask = 1'b0, in1 = 1'b0, in2 = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0, prdata, rv, d;
  logic pready, pslverr, er, live1, live2, p1, p2, swap, bias, div;
  logic src, dis, irq, cap;
  logic [7:0] pb_out, pb_oe, pb_pd;
  int mismatches = 0, samples_checked = 0, cyc = 0, i;
  always #4 mclk = ~mclk;
  aco_top aco_top_inst (.mclk, .rst_n, .psel, .penable, .pwrite, .paddr,
    .pwdata, .pstrb(4'hF), .prdata, .pready, .pslverr,
    .first_comparator_live_output(live1),
    .second_comparator_live_output(live2),
    .timer_compare_level(tcl), .extra_analog_option_mask(mask),
    .port_b_in(8'h00), .port_b_out(pb_out), .port_b_oe(pb_oe),
    .port_b_pulldown_en(pb_pd), .first_comparator_power(p1),
    .second_comparator_power(p2), .bias_power(bias),
    .comparator_sense_swap(swap), .divider_connect(div),
    .current_source_on(src), .discharge_on(dis), .analog_irq(irq),
    .capture_trigger(cap));
  aco_analog_model aco_analog_model_inst (.pwr1(p1), .pwr2(p2),
    .swap(swap), .in1(in1), .in2(in2), .out1(live1), .out2(live2));
  // =====================================================
  // shared tasks
  task automatic chk(input string n, input logic [31:0] e,
    input logic [31:0] g);
    samples_checked++;
    if (g !== e) begin
      mismatches++;
      $display("BAD %s expected %h seen %h", n, e, g);
    end
  endtask
  // request held until pready is seen at a rising edge
  task automatic apb(input logic w, input logic [7:0] x,
    input logic [31:0] v);
    @(posedge mclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= {x[5:0], 2'b00};
    pwdata <= v;
    @(posedge mclk);
    penable <= 1'b1;
    do @(posedge mclk); while (pready !== 1'b1);
    rv = prdata;
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic summarize;
    $display("checks %0d mismatches %0d", samples_checked, mismatches);
    if (mismatches == 0 && samples_checked > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask
  // hang guard, far above the few hundred cycles needed
  always @(posedge mclk) begin
    cyc++;
    if (cyc == 20000) begin
      mismatches++;
      summarize();
    end
  end
  // =====================================================
  // main sequence
  initial begin
    rv = $urandom(32'h32fbc907);
    repeat (4) @(posedge mclk);
    rst_n <= 1'b1;
    apb(0, aco_pkg::IDX_ANALOG_CONTROL, 0);
    chk("control reset", 0, rv);
    chk("pulldown reset", 8'hFF, pb_pd);
    d = $urandom;
    apb(1, aco_pkg::IDX_PORT_B_PULLDOWN_DISABLE, d);
    @(negedge mclk);
    chk("pulldown", 32'(8'(~d[7:0])), pb_pd);
    $display("test reset and pulldown done");
    apb(1, aco_pkg::IDX_PORT_B_DIRECTION, 32'h10);
    in1 <= 1'b1;
    // each OR source is walked alone and combined
    for (i = 0; i < 16; i++) begin
      d = $urandom & 32'hEF | (i[3] << 4);
      apb(1, aco_pkg::IDX_PORT_B_DATA, d);
      apb(1, aco_pkg::IDX_ANALOG_CONTROL, 32'h01 | (i[0] << 6));
      tcl <= i[2];
      mask <= i[1];
      @(negedge mclk);
      chk("pin four", {d[7:5], i[3] | i[2] | i[1] & i[0], d[3:0]}, pb_out);
      chk("pin four oe", 3'b100, {pb_oe[4], pb_pd[4], pb_oe[3]});
    end
    $display("test shared pin done");
    apb(1, aco_pkg::IDX_PORT_B_DIRECTION, 32'h01);
    for (i = 0; i < 16; i++) begin
      apb(1, aco_pkg::IDX_ANALOG_CONTROL, i[3:0]);
      apb(1, aco_pkg::IDX_ANALOG_SELECT, i[1:0]);
      @(negedge mclk);
      chk("analog ctl", {i[0], i[1], i[0] | i[1], i[2] & i[3],
        i[2] & ~i[3], ~i[2], i[0], i[1]},
        {p1, p2, bias, src, dis, pb_oe[0], swap, div});
    end
    $display("test current and power done");
    // settle time given by the writes before any flag use
    apb(1, aco_pkg::IDX_ANALOG_SELECT, 0);
    apb(1, aco_pkg::IDX_ANALOG_CONTROL, 32'h23);
    in1 <= 1'b0;
    // both flags cleared after the sense swap changed
    apb(1, aco_pkg::IDX_ANALOG_STATUS, 32'h30);
    @(posedge mclk);
    in1 <= 1'b1;
    apb(0, aco_pkg::IDX_ANALOG_STATUS, 0);
    chk("live before flag", 32'h04, rv);
    // pulses spaced well apart, polled not chased
    repeat (2) @(posedge mclk);
    in1 <= 1'b0;
    apb(0, aco_pkg::IDX_ANALOG_STATUS, 0);
    chk("flag one", 32'h01, rv);
    chk("analog irq", 1, irq);
    apb(1, aco_pkg::IDX_ANALOG_STATUS, 32'h10);
    apb(0, aco_pkg::IDX_ANALOG_STATUS, 0);
    chk("flag cleared", 0, {rv[30:0], irq});
    apb(1, aco_pkg::IDX_ANALOG_CONTROL, 32'h33);
    in2 <= 1'b1;
    repeat (4) @(posedge mclk);
    @(negedge mclk);
    chk("capture wins", 2'b10, {cap, irq});
    $display("test flags done");
    apb(0, 8'h07, 0);
    chk("unmapped err", 1, er);
    chk("unmapped data", 0, rv);
    $display("test unmapped done");
    summarize();
  end
endmodule
